// ===== logic/itx_pkg.sv
package itx_pkg;
    localparam int INSN_W = 10;
    localparam int NIB_W = 4;
    localparam int BYTE_W = 8;

    // Instruction codes of the group
    localparam logic [9:0] OP_IRQ_OFF = 10'h004;
    localparam logic [9:0] OP_IRQ_ON = 10'h005;
    localparam logic [9:0] OP_SKIP_EXT0 = 10'h038;
    localparam logic [9:0] OP_SKIP_EXT1 = 10'h039;
    localparam logic [9:0] OP_SKIP_PIN0 = 10'h03A;
    localparam logic [9:0] OP_SKIP_PIN1 = 10'h03B;
    localparam logic [9:0] OP_RD_ICTL1 = 10'h054;
    localparam logic [9:0] OP_WR_ICTL1 = 10'h03F;
    localparam logic [9:0] OP_RD_ICTL2 = 10'h055;
    localparam logic [9:0] OP_WR_ICTL2 = 10'h03E;
    localparam logic [9:0] OP_RD_ECFG0 = 10'h253;
    localparam logic [9:0] OP_WR_ECFG0 = 10'h217;
    localparam logic [9:0] OP_RD_ECFG1 = 10'h254;
    localparam logic [9:0] OP_WR_ECFG1 = 10'h218;
    localparam logic [9:0] OP_WR_PORTCTL = 10'h2AA;
    localparam logic [9:0] OP_RD_TCTL1 = 10'h24B;
    localparam logic [9:0] OP_WR_TCTL1 = 10'h20E;
    localparam logic [9:0] OP_RD_TCTL2 = 10'h24C;
    localparam logic [9:0] OP_WR_TCTL2 = 10'h20F;
    localparam logic [9:0] OP_RD_TCTL3 = 10'h24D;
    localparam logic [9:0] OP_WR_TCTL3 = 10'h210;
    localparam logic [9:0] OP_RD_TCTL4 = 10'h24E;
    localparam logic [9:0] OP_WR_TCTL4 = 10'h211;
    localparam logic [9:0] OP_RD_TCTL5 = 10'h24F;
    localparam logic [9:0] OP_WR_TCTL5 = 10'h212;
    localparam logic [9:0] OP_RD_TCTL6 = 10'h250;
    localparam logic [9:0] OP_WR_TCTL6 = 10'h213;
    localparam logic [9:0] OP_RD_PRESC = 10'h275;
    localparam logic [9:0] OP_WR_PRESC = 10'h235;
    localparam logic [9:0] OP_RD_TMR1 = 10'h270;
    localparam logic [9:0] OP_LD_TMR1 = 10'h230;
    localparam logic [9:0] OP_RD_TMR2 = 10'h271;
    localparam logic [9:0] OP_LD_TMR2 = 10'h231;
    localparam logic [9:0] OP_RD_TMR3 = 10'h272;
    localparam logic [9:0] OP_LD_TMR3 = 10'h232;
    localparam logic [9:0] OP_RD_TMR4 = 10'h273;
    localparam logic [9:0] OP_LD_TMR4 = 10'h233;
    localparam logic [9:0] OP_LD_T4_HI_RLD = 10'h237;
    localparam logic [9:0] OP_LD_T1_RLD = 10'h23F;
    localparam logic [9:0] OP_LD_T3_RLD = 10'h23B;
    localparam logic [9:0] OP_COPY_LO_T4 = 10'h297;

    // Field positions
    localparam int EXT0_MASK_POS = 0;
    localparam int EXT1_MASK_POS = 1;
    localparam int EXT_POL_POS = 2;

    // Values after reset
    localparam logic [3:0] NIB_RST = 4'h0;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic IRQ_MASTER_RST = 1'b0;
endpackage

// ===== logic/itx_skip_eval.sv
`timescale 1ns/1ns
// Combinational skip decision for the four skip tests of the group.
module itx_skip_eval
    import itx_pkg::*;
(
    input wire logic [INSN_W-1:0] insn,
    input wire logic insn_valid,
    input wire logic [NIB_W-1:0] irq_ctl_one,
    input wire logic [NIB_W-1:0] ext0_cfg_reg,
    input wire logic [NIB_W-1:0] ext1_cfg_reg,
    input wire logic ext0_req_flag,
    input wire logic ext1_req_flag,
    input wire logic ext_pin_zero,
    input wire logic ext_pin_one,
    output logic skip_take,
    output logic ext0_clr,
    output logic ext1_clr
);
    logic ext0_mask_bit;
    logic ext1_mask_bit;
    logic ext0_pol_bit;
    logic ext1_pol_bit;

    assign ext0_mask_bit = irq_ctl_one[EXT0_MASK_POS];
    assign ext1_mask_bit = irq_ctl_one[EXT1_MASK_POS];
    assign ext0_pol_bit = ext0_cfg_reg[EXT_POL_POS];
    assign ext1_pol_bit = ext1_cfg_reg[EXT_POL_POS];

    always_comb begin
        skip_take = 1'b0;
        ext0_clr = 1'b0;
        ext1_clr = 1'b0;
        if (insn_valid) begin
            if (insn == OP_SKIP_EXT0) begin
                // A set mask turns the test into a no-operation
                ext0_clr = !ext0_mask_bit && ext0_req_flag;
                skip_take = ext0_clr;
            end else if (insn == OP_SKIP_EXT1) begin
                ext1_clr = !ext1_mask_bit && ext1_req_flag;
                skip_take = ext1_clr;
            end else if (insn == OP_SKIP_PIN0) begin
                skip_take = (ext_pin_zero == ext0_pol_bit);
            end else if (insn == OP_SKIP_PIN1) begin
                skip_take = (ext_pin_one == ext1_pol_bit);
            end
        end
    end
endmodule

// ===== logic/itx_core.sv
`timescale 1ns/1ns
module itx_core
    import itx_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [INSN_W-1:0] insn,
    input wire logic insn_valid,
    input wire logic [NIB_W-1:0] acc_lo,
    input wire logic [NIB_W-1:0] acc_hi,
    input wire logic ext0_req_set,
    input wire logic ext1_req_set,
    input wire logic ext_pin_zero,
    input wire logic ext_pin_one,
    input wire logic [BYTE_W-1:0] presc_now,
    input wire logic [BYTE_W-1:0] tmr_one_now,
    input wire logic [BYTE_W-1:0] tmr_two_now,
    input wire logic [BYTE_W-1:0] tmr_three_now,
    input wire logic [BYTE_W-1:0] tmr_four_now,
    output logic irq_master_flag,
    output logic ext0_req_flag,
    output logic ext1_req_flag,
    output logic skip_next,
    output logic lo_wr,
    output logic [NIB_W-1:0] lo_data,
    output logic hi_wr,
    output logic [NIB_W-1:0] hi_data,
    output logic [NIB_W-1:0] irq_ctl_one,
    output logic [NIB_W-1:0] irq_ctl_two,
    output logic [NIB_W-1:0] ext0_cfg_reg,
    output logic [NIB_W-1:0] ext1_cfg_reg,
    output logic tmr_port_ctl,
    output logic [NIB_W-1:0] tmr_ctl_one,
    output logic [NIB_W-1:0] tmr_ctl_two,
    output logic [NIB_W-1:0] tmr_ctl_three,
    output logic [NIB_W-1:0] tmr_ctl_four,
    output logic [NIB_W-1:0] tmr_ctl_five,
    output logic [NIB_W-1:0] tmr_ctl_six,
    output logic [BYTE_W-1:0] prescale_reload,
    output logic [BYTE_W-1:0] tmr_one_reload,
    output logic [BYTE_W-1:0] tmr_two_reload,
    output logic [BYTE_W-1:0] tmr_three_reload,
    output logic [BYTE_W-1:0] tmr_four_reload_lo,
    output logic [BYTE_W-1:0] tmr_four_reload_hi,
    output logic presc_ld,
    output logic tmr_one_ld,
    output logic tmr_two_ld,
    output logic tmr_three_ld,
    output logic tmr_four_ld,
    output logic [BYTE_W-1:0] cnt_ld_val
);
    logic skip_take;
    logic ext0_clr;
    logic ext1_clr;
    logic [BYTE_W-1:0] pair;
    logic go;
    logic presc_wr_hit;
    logic t4_copy_hit;

    // Exact match on all ten bits so codes of other groups never alias in
    function automatic logic hit(input logic [INSN_W-1:0] w, input logic [INSN_W-1:0] op);
        hit = (w == op);
    endfunction

    assign pair = {acc_hi, acc_lo};
    assign go = insn_valid;
    assign presc_wr_hit = go && hit(insn, OP_WR_PRESC);
    assign t4_copy_hit = go && hit(insn, OP_COPY_LO_T4);

    // Nibble pairing and the exact ten-bit match leave no room for other widths
    if (BYTE_W != 2 * NIB_W) begin : g_byte_w_chk
        $error("byte width must be two nibbles");
    end
    if (INSN_W != 10) begin : g_insn_w_chk
        $error("instruction word must be ten bits");
    end
    // Mask and polarity positions must fall inside a control nibble
    if (EXT0_MASK_POS >= NIB_W) begin : g_mask0_chk
        $error("external-0 mask position outside the nibble");
    end
    if (EXT1_MASK_POS >= NIB_W) begin : g_mask1_chk
        $error("external-1 mask position outside the nibble");
    end
    if (EXT_POL_POS >= NIB_W) begin : g_pol_chk
        $error("polarity position outside the nibble");
    end

    itx_skip_eval u_skip (
        .insn(insn),
        .insn_valid(insn_valid),
        .irq_ctl_one(irq_ctl_one),
        .ext0_cfg_reg(ext0_cfg_reg),
        .ext1_cfg_reg(ext1_cfg_reg),
        .ext0_req_flag(ext0_req_flag),
        .ext1_req_flag(ext1_req_flag),
        .ext_pin_zero(ext_pin_zero),
        .ext_pin_one(ext_pin_one),
        .skip_take(skip_take),
        .ext0_clr(ext0_clr),
        .ext1_clr(ext1_clr)
    );

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_master_flag <= IRQ_MASTER_RST;
        end else if (go && hit(insn, OP_IRQ_OFF)) begin
            irq_master_flag <= 1'b0;
        end else if (go && hit(insn, OP_IRQ_ON)) begin
            irq_master_flag <= 1'b1;
        end
    end

    // A request arriving in the clearing cycle wins so no edge is lost
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ext0_req_flag <= 1'b0;
            ext1_req_flag <= 1'b0;
        end else begin
            if (ext0_req_set) begin
                ext0_req_flag <= 1'b1;
            end else if (ext0_clr) begin
                ext0_req_flag <= 1'b0;
            end
            if (ext1_req_set) begin
                ext1_req_flag <= 1'b1;
            end else if (ext1_clr) begin
                ext1_req_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            skip_next <= 1'b0;
        end else begin
            // Registered so the sequencer drops the next word one cycle later
            skip_next <= skip_take;
        end
    end

    // Data nibble results, one cycle after the instruction
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            lo_wr <= 1'b0;
            hi_wr <= 1'b0;
            lo_data <= NIB_RST;
            hi_data <= NIB_RST;
        end else begin
            lo_wr <= 1'b0;
            hi_wr <= 1'b0;
            if (go) begin
                if (hit(insn, OP_RD_ICTL1)) begin
                    lo_wr <= 1'b1;
                    lo_data <= irq_ctl_one;
                end else if (hit(insn, OP_RD_ICTL2)) begin
                    lo_wr <= 1'b1;
                    lo_data <= irq_ctl_two;
                end else if (hit(insn, OP_RD_ECFG0)) begin
                    lo_wr <= 1'b1;
                    lo_data <= ext0_cfg_reg;
                end else if (hit(insn, OP_RD_ECFG1)) begin
                    lo_wr <= 1'b1;
                    lo_data <= ext1_cfg_reg;
                end else if (hit(insn, OP_RD_TCTL1)) begin
                    lo_wr <= 1'b1;
                    lo_data <= tmr_ctl_one;
                end else if (hit(insn, OP_RD_TCTL2)) begin
                    lo_wr <= 1'b1;
                    lo_data <= tmr_ctl_two;
                end else if (hit(insn, OP_RD_TCTL3)) begin
                    lo_wr <= 1'b1;
                    lo_data <= tmr_ctl_three;
                end else if (hit(insn, OP_RD_TCTL4)) begin
                    lo_wr <= 1'b1;
                    lo_data <= tmr_ctl_four;
                end else if (hit(insn, OP_RD_TCTL5)) begin
                    lo_wr <= 1'b1;
                    lo_data <= tmr_ctl_five;
                end else if (hit(insn, OP_RD_TCTL6)) begin
                    lo_wr <= 1'b1;
                    lo_data <= tmr_ctl_six;
                end else if (hit(insn, OP_RD_PRESC)) begin
                    lo_wr <= 1'b1;
                    hi_wr <= 1'b1;
                    {hi_data, lo_data} <= presc_now;
                end else if (hit(insn, OP_RD_TMR1)) begin
                    lo_wr <= 1'b1;
                    hi_wr <= 1'b1;
                    {hi_data, lo_data} <= tmr_one_now;
                end else if (hit(insn, OP_RD_TMR2)) begin
                    lo_wr <= 1'b1;
                    hi_wr <= 1'b1;
                    {hi_data, lo_data} <= tmr_two_now;
                end else if (hit(insn, OP_RD_TMR3)) begin
                    lo_wr <= 1'b1;
                    hi_wr <= 1'b1;
                    {hi_data, lo_data} <= tmr_three_now;
                end else if (hit(insn, OP_RD_TMR4)) begin
                    lo_wr <= 1'b1;
                    hi_wr <= 1'b1;
                    {hi_data, lo_data} <= tmr_four_now;
                end
            end
        end
    end

    // Nibble control registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_ctl_one <= NIB_RST;
            irq_ctl_two <= NIB_RST;
            ext0_cfg_reg <= NIB_RST;
            ext1_cfg_reg <= NIB_RST;
            tmr_port_ctl <= 1'b0;
        end else if (go) begin
            if (hit(insn, OP_WR_ICTL1)) begin
                irq_ctl_one <= acc_lo;
            end
            if (hit(insn, OP_WR_ICTL2)) begin
                irq_ctl_two <= acc_lo;
            end
            if (hit(insn, OP_WR_ECFG0)) begin
                ext0_cfg_reg <= acc_lo;
            end
            if (hit(insn, OP_WR_ECFG1)) begin
                ext1_cfg_reg <= acc_lo;
            end
            // Only bit 0 is implemented; there is no read path for it
            if (hit(insn, OP_WR_PORTCTL)) begin
                tmr_port_ctl <= acc_lo[0];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tmr_ctl_one <= NIB_RST;
            tmr_ctl_two <= NIB_RST;
            tmr_ctl_three <= NIB_RST;
            tmr_ctl_four <= NIB_RST;
            tmr_ctl_five <= NIB_RST;
            tmr_ctl_six <= NIB_RST;
        end else if (go) begin
            if (hit(insn, OP_WR_TCTL1)) begin
                tmr_ctl_one <= acc_lo;
            end
            if (hit(insn, OP_WR_TCTL2)) begin
                tmr_ctl_two <= acc_lo;
            end
            if (hit(insn, OP_WR_TCTL3)) begin
                tmr_ctl_three <= acc_lo;
            end
            if (hit(insn, OP_WR_TCTL4)) begin
                tmr_ctl_four <= acc_lo;
            end
            if (hit(insn, OP_WR_TCTL5)) begin
                tmr_ctl_five <= acc_lo;
            end
            if (hit(insn, OP_WR_TCTL6)) begin
                tmr_ctl_six <= acc_lo;
            end
        end
    end

    // Reload registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prescale_reload <= BYTE_RST;
            tmr_one_reload <= BYTE_RST;
            tmr_two_reload <= BYTE_RST;
            tmr_three_reload <= BYTE_RST;
            tmr_four_reload_lo <= BYTE_RST;
            tmr_four_reload_hi <= BYTE_RST;
        end else if (go) begin
            if (hit(insn, OP_WR_PRESC)) begin
                prescale_reload <= pair;
            end
            if (hit(insn, OP_LD_TMR1)) begin
                tmr_one_reload <= pair;
            end
            if (hit(insn, OP_LD_T1_RLD)) begin
                tmr_one_reload <= pair;
            end
            if (hit(insn, OP_LD_TMR2)) begin
                tmr_two_reload <= pair;
            end
            if (hit(insn, OP_LD_TMR3)) begin
                tmr_three_reload <= pair;
            end
            if (hit(insn, OP_LD_T3_RLD)) begin
                tmr_three_reload <= pair;
            end
            if (hit(insn, OP_LD_TMR4)) begin
                tmr_four_reload_lo <= pair;
            end
            if (hit(insn, OP_LD_T4_HI_RLD)) begin
                tmr_four_reload_hi <= pair;
            end
        end
    end

    // Count load strobes to the timer counters; reload-only ops raise none
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            presc_ld <= 1'b0;
            tmr_one_ld <= 1'b0;
            tmr_two_ld <= 1'b0;
            tmr_three_ld <= 1'b0;
            tmr_four_ld <= 1'b0;
            cnt_ld_val <= BYTE_RST;
        end else begin
            presc_ld <= presc_wr_hit;
            tmr_one_ld <= go && hit(insn, OP_LD_TMR1);
            tmr_two_ld <= go && hit(insn, OP_LD_TMR2);
            tmr_three_ld <= go && hit(insn, OP_LD_TMR3);
            tmr_four_ld <= (go && hit(insn, OP_LD_TMR4)) || t4_copy_hit;
            if (t4_copy_hit) begin
                cnt_ld_val <= tmr_four_reload_lo;
            end else if (go) begin
                cnt_ld_val <= pair;
            end
        end
    end
endmodule

// ===== test/itx_core_chk.sv
`timescale 1ns/1ns
module itx_core_chk
    import itx_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [INSN_W-1:0] insn,
    input wire logic insn_valid,
    input wire logic [NIB_W-1:0] acc_lo,
    input wire logic [NIB_W-1:0] acc_hi,
    input wire logic ext0_req_set,
    input wire logic ext_pin_zero,
    input wire logic [BYTE_W-1:0] presc_now,
    input wire logic irq_master_flag,
    input wire logic ext0_req_flag,
    input wire logic skip_next,
    input wire logic lo_wr,
    input wire logic hi_wr,
    input wire logic [NIB_W-1:0] lo_data,
    input wire logic [NIB_W-1:0] hi_data,
    input wire logic [NIB_W-1:0] irq_ctl_one,
    input wire logic [NIB_W-1:0] ext0_cfg_reg,
    input wire logic presc_ld,
    input wire logic [BYTE_W-1:0] prescale_reload,
    input wire logic tmr_four_ld,
    input wire logic [BYTE_W-1:0] tmr_four_reload_lo,
    input wire logic [BYTE_W-1:0] cnt_ld_val
);
    wire [7:0] acc_b = {acc_hi, acc_lo};
    wire pin_match = ext_pin_zero == ext0_cfg_reg[EXT_POL_POS];
    // All four skip codes share the upper eight bits
    wire is_skip = insn_valid && insn[9:2] == OP_SKIP_EXT0[9:2];
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_op(logic [9:0] op);
        insn_valid && insn == op;
    endsequence
    sequence s_ext0(logic m);
        s_op(OP_SKIP_EXT0) ##0 irq_ctl_one[EXT0_MASK_POS] == m;
    endsequence
    irq_off_a: assert property (s_op(OP_IRQ_OFF) |=> !irq_master_flag)
        else $error("master flag not cleared");
    irq_on_a: assert property (s_op(OP_IRQ_ON) |=> irq_master_flag)
        else $error("master flag not set");
    ext0_skip_a: assert property (s_ext0(1'b0) ##0 ext0_req_flag |=>
        skip_next && ext0_req_flag == $past(ext0_req_set))
        else $error("request skip wrong");
    ext0_mask_a: assert property (s_ext0(1'b1) |=>
        !skip_next && ext0_req_flag == $past(ext0_req_flag || ext0_req_set))
        else $error("masked request skip acted");
    pin_skip_a: assert property (s_op(OP_SKIP_PIN0) |=> skip_next == $past(pin_match))
        else $error("pin skip wrong");
    presc_rd_a: assert property (s_op(OP_RD_PRESC) |=>
        lo_wr && hi_wr && {hi_data, lo_data} == $past(presc_now))
        else $error("prescaler read wrong");
    presc_wr_a: assert property (s_op(OP_WR_PRESC) |=>
        presc_ld && prescale_reload == $past(acc_b) && cnt_ld_val == prescale_reload)
        else $error("prescaler write wrong");
    t4_copy_a: assert property (s_op(OP_COPY_LO_T4) |=>
        tmr_four_ld && cnt_ld_val == $past(tmr_four_reload_lo))
        else $error("timer four copy wrong");
    skip_cause_a: assert property (skip_next |-> $past(is_skip))
        else $error("skip without skip test");
endmodule

bind itx_core itx_core_chk u_chk (
    .ref_clk(ref_clk), .rst(rst), .insn(insn), .insn_valid(insn_valid),
    .acc_lo(acc_lo), .acc_hi(acc_hi), .ext0_req_set(ext0_req_set),
    .ext_pin_zero(ext_pin_zero), .presc_now(presc_now), .irq_master_flag(irq_master_flag),
    .ext0_req_flag(ext0_req_flag), .skip_next(skip_next), .lo_wr(lo_wr), .hi_wr(hi_wr),
    .lo_data(lo_data), .hi_data(hi_data), .irq_ctl_one(irq_ctl_one),
    .ext0_cfg_reg(ext0_cfg_reg), .presc_ld(presc_ld), .prescale_reload(prescale_reload),
    .tmr_four_ld(tmr_four_ld), .tmr_four_reload_lo(tmr_four_reload_lo),
    .cnt_ld_val(cnt_ld_val)
);

// ===== test/irq_timer_transfer_ops_tb_top.sv
`timescale 1ns/1ns
module irq_timer_transfer_ops_tb_top;
    import itx_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [9:0] insn = 10'h000;
    logic insn_valid = 1'b0;
    logic [3:0] acc_lo = 4'h0;
    logic [3:0] acc_hi = 4'h0;
    logic [1:0] req = 2'h0;
    logic [1:0] pin = 2'h0;
    logic [7:0] cnt [0:4] = '{default: 8'h00};
    wire [7:0] rl [0:5];
    wire [1:0] fl;
    wire [4:0] ld;
    wire [3:0] lo_data, hi_data;
    wire [7:0] cnt_ld_val;
    wire mflag, tport, skip_next, lo_wr, hi_wr;
    int seed = 32'hd8d688e2;
    int n_fail = 0;
    int check_count = 0;
    int cyc = 0;
    logic [15:0] notes [$];
    logic [15:0] seen, exp;
    logic [7:0] ab, nv [0:4], erl [0:5];
    localparam logic [9:0] WR_N [0:9] = '{OP_WR_ICTL1, OP_WR_ICTL2, OP_WR_ECFG0, OP_WR_ECFG1,
        OP_WR_TCTL1, OP_WR_TCTL2, OP_WR_TCTL3, OP_WR_TCTL4, OP_WR_TCTL5, OP_WR_TCTL6};
    localparam logic [9:0] RD_N [0:9] = '{OP_RD_ICTL1, OP_RD_ICTL2, OP_RD_ECFG0, OP_RD_ECFG1,
        OP_RD_TCTL1, OP_RD_TCTL2, OP_RD_TCTL3, OP_RD_TCTL4, OP_RD_TCTL5, OP_RD_TCTL6};
    localparam logic [9:0] RD_C [0:4] = '{OP_RD_PRESC, OP_RD_TMR1, OP_RD_TMR2, OP_RD_TMR3,
        OP_RD_TMR4};
    localparam logic [9:0] LD_C [0:4] = '{OP_WR_PRESC, OP_LD_TMR1, OP_LD_TMR2, OP_LD_TMR3,
        OP_LD_TMR4};
    localparam logic [9:0] SK [0:3] = '{OP_SKIP_EXT0, OP_SKIP_EXT1, OP_SKIP_PIN0, OP_SKIP_PIN1};

    itx_core dut (
        .ref_clk(ref_clk), .rst(rst), .insn(insn), .insn_valid(insn_valid), .acc_lo(acc_lo),
        .acc_hi(acc_hi), .ext0_req_set(req[0]), .ext1_req_set(req[1]), .ext_pin_zero(pin[0]),
        .ext_pin_one(pin[1]), .presc_now(cnt[0]), .tmr_one_now(cnt[1]), .tmr_two_now(cnt[2]),
        .tmr_three_now(cnt[3]), .tmr_four_now(cnt[4]), .irq_master_flag(mflag),
        .ext0_req_flag(fl[0]), .ext1_req_flag(fl[1]), .skip_next(skip_next), .lo_wr(lo_wr),
        .lo_data(lo_data), .hi_wr(hi_wr), .hi_data(hi_data), .irq_ctl_one(), .irq_ctl_two(),
        .ext0_cfg_reg(), .ext1_cfg_reg(), .tmr_port_ctl(tport), .tmr_ctl_one(),
        .tmr_ctl_two(), .tmr_ctl_three(), .tmr_ctl_four(), .tmr_ctl_five(), .tmr_ctl_six(),
        .prescale_reload(rl[0]), .tmr_one_reload(rl[1]), .tmr_two_reload(rl[2]),
        .tmr_three_reload(rl[3]), .tmr_four_reload_lo(rl[4]), .tmr_four_reload_hi(rl[5]),
        .presc_ld(ld[4]), .tmr_one_ld(ld[3]), .tmr_two_ld(ld[2]), .tmr_three_ld(ld[1]),
        .tmr_four_ld(ld[0]), .cnt_ld_val(cnt_ld_val)
    );

    task automatic complete_run;
        $display("Checks %0d, errors %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk_reg(input string what, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic chk_ev(input logic [15:0] e, input logic [15:0] g);
        chk_reg("event", e, g);
    endtask

    // Event note: skip, lo_wr, hi_wr, five load strobes, then the data byte
    task automatic run(input logic [9:0] op, input logic [15:0] ev, input int sel = -1);
        @(posedge ref_clk);
        insn <= op;
        insn_valid <= 1'b1;
        {acc_hi, acc_lo} <= ab;
        for (int j = 0; j < 5; j++) begin
            nv[j] = 8'($random(seed));
            cnt[j] <= nv[j];
        end
        if (sel >= 0) ev[7:0] = nv[sel];
        if (ev != 16'h0000) notes.push_back(ev);
    endtask

    task automatic settle;
        @(posedge ref_clk);
        insn_valid <= 1'b0;
        @(negedge ref_clk);
    endtask

    task automatic pulse_req(input int k);
        @(posedge ref_clk);
        insn_valid <= 1'b0;
        req[k] <= 1'b1;
        @(posedge ref_clk);
        req[k] <= 1'b0;
    endtask

    // Hi or lo data is masked when its strobe is low, since it need not hold then
    always @(negedge ref_clk) begin
        if (!rst && (skip_next || lo_wr || hi_wr || |ld)) begin
            seen = {skip_next, lo_wr, hi_wr, ld, 8'h00};
            if (|ld) seen[7:0] = cnt_ld_val;
            else seen[7:0] = {hi_wr ? hi_data : 4'h0, lo_wr ? lo_data : 4'h0};
            exp = (notes.size() > 0) ? notes.pop_front() : 16'h0000;
            chk_ev(exp, seen);
        end
    end

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            complete_run;
        end
    end

    initial begin
        forever #25 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        ab = 8'($random(seed));
        run(OP_IRQ_ON, 0);
        run(OP_IRQ_OFF, 0);
        run(OP_IRQ_ON, 0);
        settle;
        chk_reg("master", 1, mflag);
        run(OP_IRQ_OFF, 0);
        settle;
        chk_reg("master", 0, mflag);
        for (int i = 0; i < 10; i++) begin
            ab = 8'($random(seed));
            run(WR_N[i], 0);
            run(RD_N[i], 16'h4000 | ab[3:0]);
        end
        ab = 8'($random(seed));
        run(OP_WR_PORTCTL, 0);
        settle;
        chk_reg("port", ab[0], tport);
        for (int k = 0; k < 5; k++) run(RD_C[k], 16'h6000, k);
        for (int k = 0; k < 5; k++) begin
            ab = 8'($random(seed));
            erl[k] = ab;
            run(LD_C[k], (16'h1000 >> k) | ab);
        end
        ab = 8'($random(seed));
        erl[5] = ab;
        run(OP_LD_T4_HI_RLD, 0);
        ab = 8'($random(seed));
        erl[1] = ab;
        run(OP_LD_T1_RLD, 0);
        ab = 8'($random(seed));
        erl[3] = ab;
        run(OP_LD_T3_RLD, 0);
        run(OP_COPY_LO_T4, 16'h0100 | erl[4]);
        settle;
        for (int k = 0; k < 6; k++) chk_reg("reload", erl[k], rl[k]);
        for (int k = 0; k < 2; k++) begin
            ab = 8'h00;
            run(OP_WR_ICTL1, 0);
            pulse_req(k);
            run(SK[k], 16'h8000);
            run(SK[k], 0);
            ab = 8'h03;
            run(OP_WR_ICTL1, 0);
            pulse_req(k);
            run(SK[k], 0);
            settle;
            chk_reg("request", 1, fl[k]);
        end
        for (int q = 0; q < 8; q++) begin
            ab = {5'h00, q[0], 2'h0};
            run(WR_N[2 + q[2]], 0);
            pin[q[2]] <= q[1];
            run(SK[2 + q[2]], (q[1] == q[0]) ? 16'h8000 : 16'h0000);
        end
        settle;
        // Let the watcher take the last note off before counting leftovers
        @(posedge ref_clk);
        chk_reg("pending", 0, 16'(notes.size()));
        complete_run;
    end
endmodule
